// ===== rtl/ieee488_ctl.sv
// bus controller: software orders over AHB-Lite, drives the IEEE-488 lines
// assumes one AHB-Lite master, bus pins synchronous to I_CLK, open-drain drivers outside
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module ieee488_ctl (
  input  wire logic        I_CLK,
  input  wire logic        I_SRST,
  input  wire logic        I_CE,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic             O_HREADYOUT,
  output logic [31:0]      O_HRDATA,
  output logic             O_HRESP,
  output logic             O_ATN_N,
  output logic             O_ATN_OE,
  output logic             O_REN_N,
  output logic             O_REN_OE,
  output logic             O_IFC_N,
  output logic             O_IFC_OE,
  input  wire logic        I_EOI_N,
  output logic             O_EOI_N,
  output logic             O_EOI_OE,
  input  wire logic        I_DAV_N,
  output logic             O_DAV_N,
  output logic             O_DAV_OE,
  input  wire logic        I_NRFD_N,
  output logic             O_NRFD_N,
  output logic             O_NRFD_OE,
  input  wire logic        I_NDAC_N,
  output logic             O_NDAC_N,
  output logic             O_NDAC_OE,
  input  wire logic [7:0]  I_DIO_N,
  output logic [7:0]       O_DIO_N,
  output logic [7:0]       O_DIO_OE,
  input  wire logic        I_SRQ_N
);
  // ---- register state ----
  logic        ctrl_ren, ctrl_atn, ctrl_lsn;
  logic        next_ren, next_atn, next_lsn;
  logic [11:0] ifc_cnt, next_ifc_cnt;
  logic        tx_start, next_tx_start;
  logic [7:0]  tx_byte, next_tx_byte;
  logic        tx_eoi, next_tx_eoi;
  logic [7:0]  rx_byte, next_rx_byte;
  logic        rx_eoi, next_rx_eoi;
  logic        rx_atn, next_rx_atn;
  logic        rx_valid, next_rx_valid;
  logic        wr_pend, next_wr_pend;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic        next_ren_oe, next_atn_oe, next_ifc_oe;

  // ---- handshake engine wires ----
  logic        src_busy;
  logic        src_dav, src_eoi;
  logic [7:0]  src_dio;
  logic        acc_nrfd, acc_ndac, acc_eoi, acc_got;
  logic [7:0]  acc_byte;
  logic        acc_en;
  logic        addr_phase;
  logic        rd_clear;

  assign addr_phase = I_HSEL && I_HTRANS[1] && I_HREADY;
  // the controller never listens to its own commands, and stops listening on a clear
  assign acc_en     = ctrl_lsn && !O_ATN_OE && !O_IFC_OE;  // R1

  ieee488_src_hs u_src (
    .i_clk    (I_CLK),
    .i_srst   (I_SRST),
    .i_ce     (I_CE),
    .i_abort  (O_IFC_OE),
    .i_start  (tx_start),
    .i_byte   (tx_byte),
    .i_eoi    (tx_eoi),
    .i_nrfd_n (I_NRFD_N),
    .i_ndac_n (I_NDAC_N),
    .o_busy   (src_busy),
    .o_dav_oe (src_dav),
    .o_dio_oe (src_dio),
    .o_eoi_oe (src_eoi)
  );

  ieee488_acc_hs u_acc (
    .i_clk     (I_CLK),
    .i_srst    (I_SRST),
    .i_ce      (I_CE),
    .i_en      (acc_en),
    .i_hold    (rx_valid),
    .i_dav_n   (I_DAV_N),
    .i_dio_n   (I_DIO_N),
    .i_eoi_n   (I_EOI_N),
    .o_nrfd_oe (acc_nrfd),
    .o_ndac_oe (acc_ndac),
    .o_byte    (acc_byte),
    .o_eoi     (acc_eoi),
    .o_got     (acc_got)
  );

  // bus line outputs: open-drain, the level is always low and the enable asserts
  assign O_DAV_OE  = src_dav;                                // R11
  assign O_DIO_OE  = src_dio;                                // R18
  assign O_EOI_OE  = src_eoi;
  assign O_NRFD_OE = acc_nrfd;                               // R11
  assign O_NDAC_OE = acc_ndac;

  always_comb begin
    next_ren      = ctrl_ren;
    next_atn      = ctrl_atn;
    next_lsn      = ctrl_lsn;
    next_ifc_cnt  = ifc_cnt;
    next_tx_start = 1'b0;
    next_tx_byte  = tx_byte;
    next_tx_eoi   = tx_eoi;
    next_wr_pend  = 1'b0;
    next_wr_addr  = wr_addr;
    next_hrdata   = O_HRDATA;
    rd_clear      = 1'b0;

    if (ifc_cnt != 12'h000) begin
      next_ifc_cnt = ifc_cnt - 12'h001;
    end

    // write data phase
    if (wr_pend) begin
      case (wr_addr)
        ieee488_ctl_pkg::OFS_CTRL: begin
          next_ren = I_HWDATA[ieee488_ctl_pkg::CTRL_REN];
          next_atn = I_HWDATA[ieee488_ctl_pkg::CTRL_ATN];
          next_lsn = I_HWDATA[ieee488_ctl_pkg::CTRL_LSN];
          if (I_HWDATA[ieee488_ctl_pkg::CTRL_IFC] && ifc_cnt == 12'h000) begin
            next_ifc_cnt = ieee488_ctl_pkg::IFC_LOAD;        // R4
          end
        end
        ieee488_ctl_pkg::OFS_TX: begin
          // a byte written while the source is busy or during a clear is dropped
          if (!src_busy && !tx_start && ifc_cnt == 12'h000) begin
            next_tx_byte  = I_HWDATA[7:0];
            // end-or-identify with attention would be a poll, so it is kept off
            next_tx_eoi   = I_HWDATA[ieee488_ctl_pkg::TX_EOI] && !O_ATN_OE;
            next_tx_start = 1'b1;                            // R17
          end
        end
        default: begin
        end
      endcase
    end

    // address phase: capture writes, answer reads in the following data phase
    if (addr_phase) begin
      if (I_HWRITE) begin
        next_wr_pend = 1'b1;
        next_wr_addr = I_HADDR[7:0];
      end else begin
        case (I_HADDR[7:0])
          ieee488_ctl_pkg::OFS_CTRL:
            next_hrdata = {28'h0, ctrl_lsn, ctrl_atn, ifc_cnt != 12'h000, ctrl_ren};
          ieee488_ctl_pkg::OFS_RX: begin
            next_hrdata = {21'h0, rx_atn, rx_valid, rx_eoi, rx_byte};
            rd_clear    = 1'b1;
          end
          ieee488_ctl_pkg::OFS_STAT:
            next_hrdata = {26'h0, O_ATN_OE, O_REN_OE, O_IFC_OE,
                           !I_SRQ_N, rx_valid, src_busy || tx_start}; // R10
          default: next_hrdata = ieee488_ctl_pkg::RD_ZERO;
        endcase
      end
    end

    // a newly accepted byte wins over a read that clears the previous one
    next_rx_byte  = rx_byte;
    next_rx_eoi   = rx_eoi;
    next_rx_atn   = rx_atn;
    next_rx_valid = rx_valid && !rd_clear;
    if (acc_got) begin
      next_rx_byte  = acc_byte;
      next_rx_eoi   = acc_eoi;                               // R8
      next_rx_atn   = O_ATN_OE;                              // R1
      next_rx_valid = 1'b1;
    end

    next_ren_oe = next_ren;                                  // R2
    // a clear drives its own line and releases the handshake and data lines; remote enable stays as software left it
    next_ifc_oe = (next_ifc_cnt != 12'h000) || (ifc_cnt != 12'h000); // R21
    // attention only moves between bytes it sources, never inside its own source handshake
    next_atn_oe = (src_busy || tx_start) ? O_ATN_OE : ctrl_atn; // R20
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      {ctrl_lsn, ctrl_atn, ctrl_ren} <= ieee488_ctl_pkg::CTRL_RST;
      ifc_cnt     <= 12'h000;
      tx_start    <= 1'b0;
      tx_byte     <= 8'h00;
      tx_eoi      <= 1'b0;
      rx_byte     <= 8'h00;
      rx_eoi      <= 1'b0;
      rx_atn      <= 1'b0;
      rx_valid    <= 1'b0;
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      O_HRDATA    <= ieee488_ctl_pkg::RD_ZERO;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      O_REN_OE    <= 1'b0;
      O_ATN_OE    <= 1'b0;
      O_IFC_OE    <= 1'b0;
      O_ATN_N     <= 1'b0;
      O_REN_N     <= 1'b0;
      O_IFC_N     <= 1'b0;
      O_EOI_N     <= 1'b0;
      O_DAV_N     <= 1'b0;
      O_NRFD_N    <= 1'b0;
      O_NDAC_N    <= 1'b0;
      O_DIO_N     <= 8'h00;
    end else if (I_CE) begin
      ctrl_ren    <= next_ren;
      ctrl_atn    <= next_atn;
      ctrl_lsn    <= next_lsn;
      ifc_cnt     <= next_ifc_cnt;
      tx_start    <= next_tx_start;
      tx_byte     <= next_tx_byte;
      tx_eoi      <= next_tx_eoi;
      rx_byte     <= next_rx_byte;
      rx_eoi      <= next_rx_eoi;
      rx_atn      <= next_rx_atn;
      rx_valid    <= next_rx_valid;
      wr_pend     <= next_wr_pend;
      wr_addr     <= next_wr_addr;
      O_HRDATA    <= next_hrdata;
      O_REN_OE    <= next_ren_oe;
      O_ATN_OE    <= next_atn_oe;
      O_IFC_OE    <= next_ifc_oe;
    end
  end

  a_ren_follow: assert property (@(posedge I_CLK) disable iff (I_SRST) // R2
    (I_CE && $past(I_CE)) |-> (O_REN_OE == ctrl_ren))
    else $error("remote enable line does not follow control");
  a_ifc_hold: assert property (@(posedge I_CLK) disable iff (I_SRST) // R4
    $rose(O_IFC_OE) |-> O_IFC_OE[*8])
    else $error("interface clear released too early");
  a_ifc_keeps_ren: assert property (@(posedge I_CLK) disable iff (I_SRST) // R7
    (O_IFC_OE && !wr_pend) |=> (ctrl_ren == $past(ctrl_ren)))
    else $error("interface clear changed remote enable");
  a_one_role: assert property (@(posedge I_CLK) disable iff (I_SRST) // R11
    !(O_DAV_OE && (O_NRFD_OE || O_NDAC_OE)))
    else $error("source and acceptor roles driven together");
  a_atn_no_accept: assert property (@(posedge I_CLK) disable iff (I_SRST) // R1
    $rose(O_ATN_OE) |=> !O_NRFD_OE && !O_NDAC_OE)
    else $error("controller still accepting under attention");
  a_atn_steady: assert property (@(posedge I_CLK) disable iff (I_SRST) // R20
    O_DAV_OE |-> $stable(O_ATN_OE))
    else $error("attention moved inside a handshake");
endmodule
`default_nettype wire

// ===== rtl/ieee488_ctl_pkg.sv
// constants shared by the bus controller top and its source handshake engine
// assumes a 40 MHz I_CLK and bus pins sampled as synchronous inputs
//
// Behaviour
// [R1] attention asserted marks bus bytes as commands, released marks them as data
// [R2] remote enable asserted low puts devices into remote preparation
// [R3] remote enable then a matching primary address puts only that device remote
// [R4] controller clears the interface by holding only the clear line low
// [R5] interface clear returns device talker and listener to idle
// [R6] interface clear turns off the talk or listen indicator
// [R7] interface clear leaves the remote state unchanged
// [R8] sender asserts end-or-identify with the final byte of a message
// [R9] device pulls service request low while it needs attention
// [R10] controller identifies the requester by reading its status word
// [R11] only the source drives data-valid; only acceptors drive the ready lines
// [R12] source waits for ready-for-data high and data-accepted low before going on
// [R13] with both acceptor lines right, source drives data-valid low
// [R14] acceptors pull ready low, then release data-accepted once byte taken
// [R15] after data-accepted rises, source releases data-valid
// [R16] after data-valid rises, acceptors pull accepted low, then release ready
// [R17] one interlocked handshake carries data and commands, paced by the slowest
// [R18] bytes travel on eight low-true bidirectional data lines, one per handshake
// [R19] device uses a configured primary bus address
// [R20] general commands go with attention low, device bytes with attention high
// [R21] a uniline command is only its own line asserted low, no byte
// [R22] every bus line is low-true
// [R23] device acts on data bytes only while addressed to listen
// [R24] device sends data only after being addressed to talk
// [R25] asynchronous bus inputs are synchronised before use; the controller uses its bus inputs unsynchronised
package ieee488_ctl_pkg;

  localparam int CLK_MHZ    = 40;
  // least data settling time before data-valid is asserted
  localparam int SETTLE_NS  = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // least time the interface clear line is held
  localparam int IFC_NS     = 100000;
  localparam int IFC_CYC    = (IFC_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);
  localparam logic [11:0] IFC_LOAD   = 12'(IFC_CYC - 1);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX   = 8'h04;
  localparam logic [7:0] OFS_RX   = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;

  // control fields
  localparam int CTRL_REN = 0;
  localparam int CTRL_IFC = 1;
  localparam int CTRL_ATN = 2;
  localparam int CTRL_LSN = 3;
  // transmit and receive fields
  localparam int TX_EOI   = 8;
  localparam int RX_EOI   = 8;
  localparam int RX_VALID = 9;
  localparam int RX_ATN   = 10;
  // status fields
  localparam int ST_BUSY  = 0;
  localparam int ST_RXV   = 1;
  localparam int ST_SRQ   = 2;
  localparam int ST_IFC   = 3;
  localparam int ST_REN   = 4;
  localparam int ST_ATN   = 5;

  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

// ===== rtl/ieee488_src_hs.sv
// source handshake engine: puts a byte on the data lines and runs data-valid
// assumes handshake inputs are line levels, synchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module ieee488_src_hs (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  input  wire logic       i_abort,
  input  wire logic       i_start,
  input  wire logic [7:0] i_byte,
  input  wire logic       i_eoi,
  input  wire logic       i_nrfd_n,
  input  wire logic       i_ndac_n,
  output logic            o_busy,
  output logic            o_dav_oe,
  output logic [7:0]      o_dio_oe,
  output logic            o_eoi_oe
);
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_SETTLE = 2'b01,
    S_VALID  = 2'b10,
    S_DROP   = 2'b11
  } src_state_e;

  src_state_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic       next_dav, next_eoi;
  logic [7:0] next_dio;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_dav   = o_dav_oe;
    next_dio   = o_dio_oe;
    next_eoi   = o_eoi_oe;
    case (state)
      S_IDLE: begin
        if (i_start) begin
          next_dio   = i_byte;                               // R18
          next_eoi   = i_eoi;                                // R8
          next_cnt   = ieee488_ctl_pkg::SETTLE_LOAD;
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (i_nrfd_n && !i_ndac_n) begin           // R12
          next_dav   = 1'b1;                                 // R13
          next_state = S_VALID;
        end
      end
      S_VALID: begin
        if (i_ndac_n) begin
          next_dav   = 1'b0;                                 // R15
          next_state = S_DROP;
        end
      end
      S_DROP: begin
        // data leave the lines one cycle after data-valid; only an abort clears them together with it
        next_dio   = 8'h00;
        next_eoi   = 1'b0;
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    if (i_abort) begin
      next_state = S_IDLE;
      next_dav   = 1'b0;
      next_dio   = 8'h00;
      next_eoi   = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state    <= S_IDLE;
      cnt      <= 8'h00;
      o_dav_oe <= 1'b0;
      o_dio_oe <= 8'h00;
      o_eoi_oe <= 1'b0;
      o_busy   <= 1'b0;
    end else if (i_ce) begin
      state    <= next_state;
      cnt      <= next_cnt;
      o_dav_oe <= next_dav;
      o_dio_oe <= next_dio;
      o_eoi_oe <= next_eoi;
      o_busy   <= (next_state != S_IDLE);
    end
  end

  a_dav_needs_ready: assert property (@(posedge i_clk) disable iff (i_srst) // R12
    $rose(o_dav_oe) |-> $past(i_nrfd_n) && !$past(i_ndac_n))
    else $error("data-valid asserted without ready lines set");
  a_dav_release: assert property (@(posedge i_clk) disable iff (i_srst) // R15
    (o_dav_oe && i_ndac_n && i_ce && !i_abort) |=> !o_dav_oe)
    else $error("data-valid not released after data accepted");
  a_data_stable: assert property (@(posedge i_clk) disable iff (i_srst) // R18
    (o_dav_oe && $past(o_dav_oe)) |-> $stable(o_dio_oe))
    else $error("data lines changed while data-valid held");
  a_eoi_with_byte: assert property (@(posedge i_clk) disable iff (i_srst) // R8
    o_eoi_oe |-> o_busy)
    else $error("end-or-identify asserted outside a byte");
endmodule
`default_nettype wire

// ===== rtl/ieee488_acc_hs.sv
// acceptor handshake engine: runs ready-for-data and data-accepted
// assumes line levels synchronous to i_clk; i_hold stalls while a byte is unread
`timescale 1ns/1ps
`default_nettype none
module ieee488_acc_hs (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  input  wire logic       i_en,
  input  wire logic       i_hold,
  input  wire logic       i_dav_n,
  input  wire logic [7:0] i_dio_n,
  input  wire logic       i_eoi_n,
  output logic            o_nrfd_oe,
  output logic            o_ndac_oe,
  output logic [7:0]      o_byte,
  output logic            o_eoi,
  output logic            o_got
);
  typedef enum logic [1:0] {
    A_OFF   = 2'b00,
    A_READY = 2'b01,
    A_TAKE  = 2'b10
  } acc_state_e;

  acc_state_e state, next_state;
  logic       next_nrfd, next_ndac, next_eoi, next_got;
  logic [7:0] next_byte;

  always_comb begin
    next_state = state;
    next_nrfd  = o_nrfd_oe;
    next_ndac  = o_ndac_oe;
    next_byte  = o_byte;
    next_eoi   = o_eoi;
    next_got   = 1'b0;
    case (state)
      A_OFF: begin
        if (i_en) begin
          next_nrfd  = 1'b1;
          next_ndac  = 1'b1;
          next_state = A_READY;
        end
      end
      A_READY: begin
        next_ndac = 1'b1;
        next_nrfd = i_hold;                                  // R16
        if (!i_dav_n && !o_nrfd_oe) begin
          next_byte  = ~i_dio_n;                             // R22
          next_eoi   = ~i_eoi_n;                             // R8
          next_got   = 1'b1;
          next_nrfd  = 1'b1;                                 // R14
          next_ndac  = 1'b0;                                 // R14
          next_state = A_TAKE;
        end
      end
      A_TAKE: begin
        if (i_dav_n) begin
          next_ndac  = 1'b1;                                 // R16
          next_state = A_READY;
        end
      end
      default: next_state = A_OFF;
    endcase
    // a disabled acceptor lets go of both lines so others can run the bus
    if (!i_en) begin
      next_state = A_OFF;
      next_nrfd  = 1'b0;
      next_ndac  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state     <= A_OFF;
      o_nrfd_oe <= 1'b0;
      o_ndac_oe <= 1'b0;
      o_byte    <= 8'h00;
      o_eoi     <= 1'b0;
      o_got     <= 1'b0;
    end else if (i_ce) begin
      state     <= next_state;
      o_nrfd_oe <= next_nrfd;
      o_ndac_oe <= next_ndac;
      o_byte    <= next_byte;
      o_eoi     <= next_eoi;
      o_got     <= next_got;
    end
  end

  a_take_on_dav: assert property (@(posedge i_clk) disable iff (i_srst) // R14
    (i_ce && i_en && state == A_READY && !i_dav_n && !o_nrfd_oe)
      |=> (o_nrfd_oe && !o_ndac_oe && o_got))
    else $error("byte not taken on data-valid");
  a_ndac_after_dav: assert property (@(posedge i_clk) disable iff (i_srst) // R16
    (i_ce && i_en && state == A_TAKE && i_dav_n) |=> o_ndac_oe)
    else $error("data-accepted not pulled low after data-valid released");
endmodule
`default_nettype wire

// ===== sim/ieee488_dev_model.sv
// behavioural instrument on the far side: listener, talker, remote and service request
// assumes the bench resolves every line as wired-low with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ieee488_dev_model #(
  parameter logic [4:0] ADDR = 5'h0B
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        i_slow,
  input  wire logic        i_srq,
  input  wire logic [7:0]  i_talk_byte,
  input  wire logic [14:0] i_lines_n,
  output logic             o_nrfd_oe,
  output logic             o_ndac_oe,
  output logic             o_dav_oe,
  output logic             o_eoi_oe,
  output logic             o_srq_oe,
  output logic [7:0]       o_dio_oe,
  output logic             o_rprep,
  output logic             o_remote,
  output logic             o_talk,
  output logic             o_listen,
  output logic [8:0]       o_last
);
  // line order {atn, ren, ifc, dav, eoi, nrfd, ndac, dio}, all low-true
  logic [14:0] s1, s2;
  logic [1:0]  acc_st, src_st;
  logic [5:0]  cnt;
  logic [6:0]  cmd;
  logic        sent, atn, acc_en;
  assign atn = ~s2[14];
  assign cmd = ~s2[6:0];
  // never accepts while sourcing, so the two engines share one counter
  assign acc_en = (atn || (o_listen && !o_talk)) && src_st == 2'h0;
  always_ff @(posedge clk) begin
    s1 <= i_lines_n;
    s2 <= s1;
    cnt <= (cnt != 6'h0) ? cnt - 6'h1 : 6'h0;
    if (rst) begin
      {o_nrfd_oe, o_ndac_oe, o_dav_oe, o_eoi_oe, o_srq_oe, o_dio_oe} <= '0;
      {o_rprep, o_remote, o_talk, o_listen, sent, acc_st, src_st} <= '0;
      o_last <= 9'h0;
    end else begin
      o_srq_oe <= i_srq;
      o_rprep <= ~s2[13];
      if (s2[13]) o_remote <= 1'b0;
      if (!s2[12]) begin
        {o_talk, o_listen, src_st, acc_st, o_dav_oe, o_eoi_oe} <= '0;
        o_dio_oe <= 8'h0;
      end else begin
        if (!acc_en) begin
          {o_nrfd_oe, o_ndac_oe, acc_st} <= '0;
        end else begin
          case (acc_st)
            2'h0: begin
              o_nrfd_oe <= !s2[11];
              o_ndac_oe <= 1'b1;
              if (!s2[11]) begin
                cnt <= i_slow ? 6'h28 : 6'h1;
                acc_st <= 2'h1;
              end
            end
            2'h1: if (cnt == 6'h0) begin
              o_ndac_oe <= 1'b0;
              acc_st <= 2'h2;
              if (!atn) o_last <= ~{s2[10], s2[7:0]};
              else if (cmd == {2'h1, ADDR}) begin
                o_listen <= 1'b1;
                o_remote <= o_remote | ~s2[13];
              end else if (cmd == 7'h3F) o_listen <= 1'b0;
              else if (cmd == {2'h2, ADDR}) begin
                o_talk <= 1'b1;
                sent <= 1'b0;
              end else if (cmd[6:5] == 2'h2) o_talk <= 1'b0;
            end
            2'h2: if (s2[11]) begin
              o_ndac_oe <= 1'b1;
              cnt <= i_slow ? 6'h28 : 6'h1;
              acc_st <= 2'h3;
            end
            default: if (cnt == 6'h0) begin
              o_nrfd_oe <= 1'b0;
              acc_st <= 2'h0;
            end
          endcase
        end
        case (src_st)
          2'h0: if (o_talk && !atn && !sent) begin
            o_dio_oe <= i_talk_byte;
            o_eoi_oe <= 1'b1;
            cnt <= 6'h4;
            src_st <= 2'h1;
          end
          2'h1: if (cnt == 6'h0 && s2[9] && !s2[8]) begin
            o_dav_oe <= 1'b1;
            src_st <= 2'h2;
          end
          2'h2: if (s2[8]) begin
            o_dav_oe <= 1'b0;
            src_st <= 2'h3;
          end
          default: begin
            {o_dio_oe, o_eoi_oe} <= '0;
            sent <= 1'b1;
            src_st <= 2'h0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/test_ieee488_ctl.sv
// self-checking bench: AHB-Lite master, wired-low bus lines, one device model
// assumes the controller answers every transfer with zero wait states
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module test_ieee488_ctl;
  localparam logic [4:0] DA = 5'h0B;
  logic        clk, srst, hwrite, slow, srq, hrdy, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  tb_byte, c_dio, d_dio;
  logic        c_atn, c_ren, c_ifc, c_eoi, c_dav, c_nrfd, c_ndac;
  logic        d_nrfd, d_ndac, d_dav, d_eoi, d_srq, rprep, remote, talk, listen;
  logic [8:0]  last;
  logic [14:0] ln;
  int          mismatches = 0;
  int          total_checks = 0;
  assign ln = ~{c_atn, c_ren, c_ifc, c_dav | d_dav, c_eoi | d_eoi, c_nrfd | d_nrfd,
                c_ndac | d_ndac, c_dio | d_dio};
  ieee488_ctl dut (
    .I_CLK(clk), .I_SRST(srst), .I_CE(1'b1), .I_HSEL(1'b1), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .O_HREADYOUT(hrdy), .O_HRDATA(hrdata), .O_HRESP(hresp),
    .O_ATN_N(), .O_ATN_OE(c_atn), .O_REN_N(), .O_REN_OE(c_ren), .O_IFC_N(),
    .O_IFC_OE(c_ifc), .I_EOI_N(ln[10]), .O_EOI_N(), .O_EOI_OE(c_eoi),
    .I_DAV_N(ln[11]), .O_DAV_N(), .O_DAV_OE(c_dav), .I_NRFD_N(ln[9]), .O_NRFD_N(),
    .O_NRFD_OE(c_nrfd), .I_NDAC_N(ln[8]), .O_NDAC_N(), .O_NDAC_OE(c_ndac),
    .I_DIO_N(ln[7:0]), .O_DIO_N(), .O_DIO_OE(c_dio), .I_SRQ_N(~d_srq)
  );
  ieee488_dev_model #(.ADDR(DA)) dev (
    .clk(clk), .rst(srst), .i_slow(slow), .i_srq(srq), .i_talk_byte(tb_byte),
    .i_lines_n(ln), .o_nrfd_oe(d_nrfd), .o_ndac_oe(d_ndac), .o_dav_oe(d_dav),
    .o_eoi_oe(d_eoi), .o_srq_oe(d_srq), .o_dio_oe(d_dio), .o_rprep(rprep),
    .o_remote(remote), .o_talk(talk), .o_listen(listen), .o_last(last)
  );
  // handshake order seen on the resolved wires, whoever is the source
  always @(negedge ln[11]) if (!srst) `CHK(ln[9:8], 2'b10)
  always @(posedge ln[11]) if (!srst) `CHK(ln[8], 1'b1)
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    ahb(a, 1'b0, 32'h0, r);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_st(input int b, input logic v);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      rd(ieee488_ctl_pkg::OFS_STAT, r);
      n++;
    end while (r[b] !== v && n < 500);
    `CHK(r[b], v)
  endtask
  task automatic send(input logic [8:0] b);
    wr(ieee488_ctl_pkg::OFS_TX, {23'h0, b});
    wait_st(ieee488_ctl_pkg::ST_BUSY, 1'b0);
  endtask
  task automatic t_reset;
    logic [31:0] r;
    `CHK({hrdy, hresp, c_atn, c_ren, c_ifc, c_eoi, c_dav, c_nrfd, c_ndac, c_dio}, 17'h10000)
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, r);
    `CHK(r, 32'h0)
    rd(ieee488_ctl_pkg::OFS_STAT, r);
    `CHK(r, 32'h0)
  endtask
  task automatic t_addr;
    wr(ieee488_ctl_pkg::OFS_CTRL, 32'h1);
    settle;
    `CHK({c_ren, rprep, remote}, 3'b110)
    wr(ieee488_ctl_pkg::OFS_CTRL, 32'h5);
    settle;
    `CHK(c_atn, 1'b1)
    send({4'h1, DA});
    settle;
    `CHK({listen, remote, talk}, 3'b110)
  endtask
  task automatic t_data;
    wr(ieee488_ctl_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      send(i[0] ? 9'h05A : 9'h181);
      `CHK(last, i[0] ? 9'h05A : 9'h181)
    end
  endtask
  task automatic t_talk;
    logic [31:0] r;
    tb_byte <= 8'hC3;
    wr(ieee488_ctl_pkg::OFS_CTRL, 32'h5);
    send({4'h2, DA});
    settle;
    `CHK(talk, 1'b1)
    wr(ieee488_ctl_pkg::OFS_CTRL, 32'h9);
    wait_st(ieee488_ctl_pkg::ST_RXV, 1'b1);
    rd(ieee488_ctl_pkg::OFS_RX, r);
    `CHK(r[10:0], 11'h3C3)
    rd(ieee488_ctl_pkg::OFS_RX, r);
    `CHK(r[9], 1'b0)
  endtask
  task automatic t_srq;
    logic [31:0] r;
    for (int i = 1; i >= 0; i--) begin
      srq <= i[0];
      settle;
      rd(ieee488_ctl_pkg::OFS_STAT, r);
      `CHK(r[ieee488_ctl_pkg::ST_SRQ], i[0])
    end
  endtask
  task automatic t_ifc;
    logic [31:0] r;
    wr(ieee488_ctl_pkg::OFS_CTRL, 32'h3);
    rd(ieee488_ctl_pkg::OFS_CTRL, r);
    `CHK({r[1], c_ifc, c_atn, c_dav}, 4'b1100)
    settle;
    `CHK({talk, listen, remote}, 3'b001)
    repeat (3993) @(posedge clk);
    @(negedge clk);
    `CHK(c_ifc, 1'b1)
    repeat (40) @(posedge clk);
    `CHK(c_ifc, 1'b0)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {srst, hwrite, slow, srq, htrans} = 6'b100000;
    {haddr, hwdata, tb_byte} = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_addr;
    t_data;
    t_talk;
    t_srq;
    t_ifc;
    end_of_test;
  end
  // the scenarios need about 5000 cycles
  initial begin
    #(25 * 30000);
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire
